/* logic/uits_buf_addr.sv */
`default_nettype none
// =============================================================
// Buffer address walker across the descriptor page pointers
module uits_buf_addr #(
   parameter int PAGES = 7,
   parameter int PW = 20,
   parameter int OW = 12
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Control
   input wire logic load,
   input wire logic [2:0] load_pg,
   input wire logic [OW-1:0] load_off,
   input wire logic step,
   input wire logic [PAGES*PW-1:0] pages,
   // Result
   output logic [PW+OW-1:0] addr
);
   logic [2:0] pg;
   logic [OW-1:0] off;
   logic [2:0] next_pg;
   logic [OW-1:0] next_off;
   logic [PW-1:0] next_page;

   always_comb
   begin
      next_pg = pg;
      next_off = off;
      if (load)
      begin
         next_pg = load_pg;
         next_off = load_off;
      end
      else if (step)
      begin
         next_off = off + 1'b1;
         if (off == {OW{1'b1}})
            next_pg = pg + 3'h1;
      end
      // Last page has no successor; pointer goes to zero, and the next crossing after that wraps pg back to page 0
      next_page = (int'(next_pg) < PAGES) ? pages[int'(next_pg)*PW +: PW] : '0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         pg <= 3'h0;
         off <= '0;
         addr <= '0;
      end
      else
      begin
         pg <= next_pg;
         off <= next_off;
         addr <= {next_page, next_off};
      end
   end
endmodule : uits_buf_addr
`default_nettype wire

/* logic/uits_pkg.sv */
`default_nettype none
// =============================================================
// Shared constants for the isochronous descriptor scheduler
package uits_pkg;
   // =============================================================
   // Timing
   localparam int UFRAME_NS = 125000;
   localparam int CLK_NS = 50;
   localparam int UFRAME_CYC = UFRAME_NS / CLK_NS;
   localparam int TMR_W = 12;

   // =============================================================
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_FRAME_INDEX = 8'h08;
   localparam logic [7:0] REG_LIST_BASE = 8'h0c;
   localparam logic [7:0] REG_CAPS = 8'h10;
   localparam logic [7:0] REG_RESULT = 8'h14;

   // =============================================================
   // Frame index and descriptor layout
   localparam int FI_W = 14;
   localparam int ITD_WORDS = 16;
   localparam int REC_BASE = 1;
   localparam int PAGE_BASE = 9;
   localparam int NUM_PAGES = 7;
   localparam int PAGE_SHIFT = 12;
   localparam int REC_ACTIVE = 31;
   localparam int REC_BABBLE = 29;
   localparam int REC_XACT_ERR = 28;
   localparam int REC_LEN_LSB = 16;
   localparam int REC_PG_LSB = 12;
   localparam int LEN_W = 12;
   localparam int LINK_T = 0;
   localparam int LINK_TYP_LSB = 1;
   localparam logic [1:0] TYP_ITD = 2'h0;
   localparam int DEV_LSB = 0;
   localparam int EP_LSB = 8;
   localparam int DIR_BIT = 11;
   localparam int MPS_W = 11;
   localparam int THR_FRAME = 7;
   localparam int THR_CNT_W = 3;

   typedef enum logic [2:0] {
      ST_IDLE, ST_LIST, ST_LINK, ST_FETCH, ST_EVAL, ST_ISSUE, ST_WAIT, ST_WB
   } uits_state_e;
endpackage : uits_pkg
`default_nettype wire

/* logic/uits_sched.sv */
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`default_nettype none
module uits_sched #(
   parameter logic [7:0] ISO_THRESH = 8'h02
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Schedule memory port
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // Link transaction engine
   output logic txn_start,
   output logic [6:0] txn_dev,
   output logic [3:0] txn_ep,
   output logic txn_in,
   output logic [uits_pkg::LEN_W-1:0] txn_len,
   output logic [31:0] txn_buf_addr,
   input wire logic data_step,
   input wire logic txn_done,
   input wire logic [uits_pkg::LEN_W-1:0] txn_bytes,
   input wire logic txn_error
);
   // =============================================================
   // Declarations
   localparam int LW = uits_pkg::LEN_W;
   localparam int PW = 32 - uits_pkg::PAGE_SHIFT;
   localparam logic [uits_pkg::TMR_W-1:0] TMR_LAST = uits_pkg::TMR_W'(uits_pkg::UFRAME_CYC - 1);

   logic ctrl_run;
   logic [PW-1:0] list_base;
   logic [uits_pkg::FI_W-1:0] frame_index_counter;
   logic [31:0] last_result;
   logic [uits_pkg::TMR_W-1:0] uf_tmr;
   logic uf_tick;
   logic ap_valid;
   logic ap_write;
   logic [7:0] ap_addr;
   logic [31:0] rd_mux;
   logic [31:0] host_capability_params;
   uits_pkg::uits_state_e state;
   logic [31:0] itd [uits_pkg::ITD_WORDS];
   logic [31:0] link;
   logic [31:0] itd_addr;
   logic [3:0] word_cnt;
   logic [2:0] cur_uf;
   logic uf_end;
   logic cache_valid;
   logic [31:0] cache_tag;
   logic [2:0] cache_age;
   logic [1:0] mult_left;
   logic [LW-1:0] rem;
   logic [LW-1:0] acc;
   logic babble;
   logic xact_err;
   logic buf_load;
   logic [31:0] rec;
   logic [LW-1:0] mps;
   logic [LW-1:0] lim;
   logic [uits_pkg::NUM_PAGES*PW-1:0] pages_flat;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign host_capability_params = {24'h0, ISO_THRESH};

   // =============================================================
   // Register bus
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr <= 8'h00;
         hrdata <= 32'h0;
      end
      else if (hready)
      begin
         ap_valid <= hsel && htrans[1];
         ap_write <= hwrite;
         ap_addr <= haddr[7:0];
         if (hsel && htrans[1] && !hwrite)
            hrdata <= rd_mux;
      end
   end

   always_comb
   begin
      case (haddr[7:0])
         uits_pkg::REG_CTRL: rd_mux = {31'h0, ctrl_run};
         uits_pkg::REG_STATUS: rd_mux = {30'h0, cache_valid, state != uits_pkg::ST_IDLE};
         uits_pkg::REG_FRAME_INDEX: rd_mux = {18'h0, frame_index_counter};
         uits_pkg::REG_LIST_BASE: rd_mux = {list_base, 12'h0};
         uits_pkg::REG_CAPS: rd_mux = host_capability_params;
         uits_pkg::REG_RESULT: rd_mux = last_result;
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         ctrl_run <= 1'b0;
         list_base <= '0;
      end
      else if (ap_valid && ap_write)
      begin
         if (ap_addr == uits_pkg::REG_CTRL)
            ctrl_run <= hwdata[0];
         if (ap_addr == uits_pkg::REG_LIST_BASE)
            list_base <= hwdata[31:uits_pkg::PAGE_SHIFT];
      end
   end

   // =============================================================
   // Microframe timer and frame index
   assign uf_tick = ctrl_run && (uf_tmr == TMR_LAST);

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         uf_tmr <= '0;
         frame_index_counter <= '0;
      end
      else
      begin
         uf_tmr <= (!ctrl_run || uf_tick) ? '0 : uf_tmr + 1'b1;
         if (uf_tick)
            frame_index_counter <= frame_index_counter + 1'b1;
         // Only writable while stopped, so software never races the counter
         else if (!ctrl_run && ap_valid && ap_write && ap_addr == uits_pkg::REG_FRAME_INDEX)
            frame_index_counter <= hwdata[uits_pkg::FI_W-1:0];
      end
   end

   // =============================================================
   // Current record and transaction sizing
   always_comb
   begin
      rec = itd[uits_pkg::REC_BASE + int'(cur_uf)];
      mps = {1'b0, itd[uits_pkg::PAGE_BASE+1][uits_pkg::MPS_W-1:0]};
      lim = (mps < rem) ? mps : rem;
      for (int i = 0; i < uits_pkg::NUM_PAGES; i++)
         pages_flat[i*PW +: PW] = itd[uits_pkg::PAGE_BASE + i][31:uits_pkg::PAGE_SHIFT];
   end

   uits_buf_addr #(
      .PAGES(uits_pkg::NUM_PAGES),
      .PW(PW),
      .OW(uits_pkg::PAGE_SHIFT)
   ) u_buf_addr (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .load(buf_load),
      .load_pg(rec[uits_pkg::REC_PG_LSB +: 3]),
      .load_off(rec[uits_pkg::PAGE_SHIFT-1:0]),
      .step(data_step),
      .pages(pages_flat),
      .addr(txn_buf_addr)
   );

   // =============================================================
   // Schedule traversal
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         state <= uits_pkg::ST_IDLE;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 32'h0;
         mem_wdata <= 32'h0;
         txn_start <= 1'b0;
         txn_dev <= 7'h0;
         txn_ep <= 4'h0;
         txn_in <= 1'b0;
         txn_len <= '0;
         link <= 32'h0;
         itd_addr <= 32'h0;
         word_cnt <= 4'h0;
         cur_uf <= 3'h0;
         uf_end <= 1'b0;
         cache_valid <= 1'b0;
         cache_tag <= 32'h0;
         cache_age <= 3'h0;
         mult_left <= 2'h0;
         rem <= '0;
         acc <= '0;
         babble <= 1'b0;
         xact_err <= 1'b0;
         buf_load <= 1'b0;
         last_result <= 32'h0;
         for (int i = 0; i < uits_pkg::ITD_WORDS; i++)
            itd[i] <= 32'h0;
      end
      else
      begin
         txn_start <= 1'b0;
         buf_load <= 1'b0;
         case (state)
            uits_pkg::ST_IDLE:
            begin
               if (uf_end)
               begin
                  uf_end <= 1'b0;
                  cur_uf <= frame_index_counter[2:0];
                  mem_addr <= {list_base, frame_index_counter[12:3], 2'b00};
                  mem_we <= 1'b0;
                  mem_req <= 1'b1;
                  state <= uits_pkg::ST_LIST;
               end
            end
            uits_pkg::ST_LIST:
            begin
               if (mem_ack)
               begin
                  mem_req <= 1'b0;
                  link <= mem_rdata;
                  state <= uits_pkg::ST_LINK;
               end
            end
            uits_pkg::ST_LINK:
            begin
               // Other structure types belong to other engines; stop here
               if (uf_end || link[uits_pkg::LINK_T] || link[uits_pkg::LINK_TYP_LSB +: 2] != uits_pkg::TYP_ITD)
                  state <= uits_pkg::ST_IDLE;
               else if (cache_valid && cache_tag == {link[31:5], 5'h0})
                  state <= uits_pkg::ST_EVAL;
               else
               begin
                  itd_addr <= {link[31:5], 5'h0};
                  mem_addr <= {link[31:5], 5'h0};
                  mem_req <= 1'b1;
                  word_cnt <= 4'h0;
                  cache_valid <= 1'b0;
                  state <= uits_pkg::ST_FETCH;
               end
            end
            uits_pkg::ST_FETCH:
            begin
               if (mem_ack)
               begin
                  itd[word_cnt] <= mem_rdata;
                  word_cnt <= word_cnt + 4'h1;
                  mem_addr <= mem_addr + 32'h4;
                  if (word_cnt == 4'(uits_pkg::ITD_WORDS - 1))
                  begin
                     mem_req <= 1'b0;
                     cache_tag <= itd_addr;
                     cache_valid <= ISO_THRESH != 8'h00;
                     state <= uits_pkg::ST_EVAL;
                  end
               end
            end
            uits_pkg::ST_EVAL:
            begin
               if (!rec[uits_pkg::REC_ACTIVE])
               begin
                  link <= itd[0];
                  state <= uits_pkg::ST_LINK;
               end
               else
               begin
                  // Zero multiplier is undefined; it runs once here
                  mult_left <= itd[uits_pkg::PAGE_BASE+2][1:0];
                  rem <= rec[uits_pkg::REC_LEN_LSB +: LW];
                  acc <= '0;
                  babble <= 1'b0;
                  xact_err <= 1'b0;
                  buf_load <= 1'b1;
                  txn_dev <= itd[uits_pkg::PAGE_BASE][uits_pkg::DEV_LSB +: 7];
                  txn_ep <= itd[uits_pkg::PAGE_BASE][uits_pkg::EP_LSB +: 4];
                  txn_in <= itd[uits_pkg::PAGE_BASE+1][uits_pkg::DIR_BIT];
                  state <= uits_pkg::ST_ISSUE;
               end
            end
            uits_pkg::ST_ISSUE:
            begin
               if (uf_end)
                  state <= uits_pkg::ST_WB;
               else
               begin
                  txn_start <= 1'b1;
                  txn_len <= lim;
                  state <= uits_pkg::ST_WAIT;
               end
            end
            uits_pkg::ST_WAIT:
            begin
               if (txn_done)
               begin
                  mult_left <= mult_left - 2'h1;
                  state <= uits_pkg::ST_WB;
                  if (txn_in && txn_bytes > lim)
                     babble <= 1'b1;
                  else if (txn_in)
                  begin
                     acc <= acc + txn_bytes;
                     rem <= rem - txn_bytes;
                     if (!txn_error && txn_bytes == mps && mult_left > 2'h1)
                        state <= uits_pkg::ST_ISSUE;
                  end
                  else
                  begin
                     rem <= rem - lim;
                     if (!txn_error && rem != lim && mult_left > 2'h1)
                        state <= uits_pkg::ST_ISSUE;
                  end
                  xact_err <= txn_error;
               end
            end
            uits_pkg::ST_WB:
            begin
               // Whole microframe reported as one record, in its cur_uf slot
               mem_we <= 1'b1;
               mem_req <= 1'b1;
               mem_addr <= itd_addr + {27'h0, cur_uf, 2'b00} + 32'(uits_pkg::REC_BASE * 4);
               mem_wdata <= {1'b0, rec[30], babble, xact_err,
                  babble ? rec[uits_pkg::REC_LEN_LSB +: LW] : (txn_in ? acc : rem),
                  rec[15:0]};
               if (mem_req && mem_ack)
               begin
                  mem_req <= 1'b0;
                  mem_we <= 1'b0;
                  itd[uits_pkg::REC_BASE + int'(cur_uf)] <= mem_wdata;
                  last_result <= mem_wdata;
                  link <= itd[0];
                  state <= uits_pkg::ST_LINK;
               end
            end
            default: state <= uits_pkg::ST_IDLE;
         endcase
         // New microframe: set wins over the clear above
         if (uf_tick)
         begin
            uf_end <= 1'b1;
            cache_age <= cache_age + 3'h1;
            if (ISO_THRESH == 8'h00)
               cache_valid <= 1'b0;
            else if (ISO_THRESH[uits_pkg::THR_FRAME])
            begin
               if (frame_index_counter[2:0] == 3'h7)
                  cache_valid <= 1'b0;
            end
            else if (cache_age + 3'h1 >= ISO_THRESH[uits_pkg::THR_CNT_W-1:0])
            begin
               cache_valid <= 1'b0;
               cache_age <= 3'h0;
            end
         end
      end
   end
endmodule : uits_sched
`default_nettype wire

/* verif/uits_checker.sv */
`default_nettype none
// ====================
// Port checker
module uits_checker #(
   parameter logic [7:0] ISO_THRESH = 8'h02
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Memory
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic mem_ack,
   // Link
   input wire logic txn_start,
   input wire logic [6:0] txn_dev,
   input wire logic [3:0] txn_ep,
   input wire logic txn_in,
   input wire logic [uits_pkg::LEN_W-1:0] txn_len,
   input wire logic [31:0] txn_buf_addr,
   input wire logic data_step,
   input wire logic txn_done
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic rd_cyc;
   assign rd_cyc = hsel && hready && htrans[1] && !hwrite;

   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay)
      else $error("bus answer not zero-wait OKAY");
   property p_caps; rd_cyc && haddr == {24'h0, uits_pkg::REG_CAPS} |=> hrdata == {24'h0, ISO_THRESH}; endproperty
   a_caps: assert property (p_caps)
      else $error("threshold read wrong");
   property p_hold; !rd_cyc |=> $stable(hrdata); endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved without a read");
   property p_pulse; txn_start |=> !txn_start; endproperty
   a_pulse: assert property (p_pulse)
      else $error("transaction start longer than one cycle");
   property p_gap; txn_done |-> !txn_start ##1 !txn_start; endproperty
   a_gap: assert property (p_gap)
      else $error("transaction start too soon after done");
   // Endpoint fields load one cycle ahead of the start, the length with it
   property p_fields; $changed(txn_len) |-> txn_start; endproperty
   a_fields: assert property (p_fields)
      else $error("transaction length moved without a start");
   property p_ident; $changed(txn_dev) || $changed(txn_ep) || $changed(txn_in) |=> txn_start; endproperty
   a_ident: assert property (p_ident)
      else $error("endpoint fields moved without a start");
   property p_mem; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata); endproperty
   a_mem: assert property (p_mem)
      else $error("memory request dropped or changed before ack");
   property p_step; data_step && !txn_start && txn_buf_addr[11:0] != 12'hfff |=> txn_buf_addr == $past(txn_buf_addr) + 32'h1; endproperty
   a_step: assert property (p_step)
      else $error("buffer address did not advance by one");
   property p_cross; data_step && !txn_start && txn_buf_addr[11:0] == 12'hfff |=>
      txn_buf_addr[11:0] == 12'h000 && txn_buf_addr[31:12] != $past(txn_buf_addr[31:12]); endproperty
   a_cross: assert property (p_cross)
      else $error("page crossing kept the old page");
endmodule : uits_checker

bind uits_sched uits_checker #(.ISO_THRESH(ISO_THRESH)) chk (.ref_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hreadyout, .hresp, .hrdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .txn_start,
   .txn_dev, .txn_ep, .txn_in, .txn_len, .txn_buf_addr, .data_step, .txn_done);
`default_nettype wire

/* verif/uits_far_model.sv */
`default_nettype none
// ====================
// Schedule memory and link engine
module uits_far_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Memory
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   // Link
   input wire logic txn_start,
   input wire logic [uits_pkg::LEN_W-1:0] txn_len,
   input wire logic [31:0] txn_buf_addr,
   output logic data_step,
   output logic txn_done,
   output logic [uits_pkg::LEN_W-1:0] txn_bytes,
   output logic txn_error,
   // Bench control and capture
   input wire logic clr,
   input wire logic cfg_babble,
   input wire logic [1:0] cfg_short_at,
   output logic [2:0] n_txn,
   output logic [uits_pkg::LEN_W-1:0] len0,
   output logic [31:0] addr0,
   output logic [31:0] addr1,
   output logic [7:0] wr_count,
   output logic [31:0] wr_addr,
   output logic [31:0] wr_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [0:1023];
   logic [1:0] dly;
   logic busy;
   logic [uits_pkg::LEN_W-1:0] left;
   assign txn_error = 1'b0;

   // Odd words answer slowly; idle read data toggles so stale values never pass
   always @(posedge ref_clk)
   begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!reset_n)
      begin
         dly <= 2'h0;
         wr_count <= 8'h00;
         mem_rdata <= 32'h0;
      end
      else if (mem_req && !mem_ack)
      begin
         dly <= dly + 2'h1;
         if (dly == {2{mem_addr[2]}})
         begin
            mem_ack <= 1'b1;
            dly <= 2'h0;
            mem_rdata <= mem[mem_addr[11:2]];
            if (mem_we)
            begin
               mem[mem_addr[11:2]] <= mem_wdata;
               wr_count <= wr_count + 8'h01;
               wr_addr <= mem_addr;
               wr_data <= mem_wdata;
            end
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      data_step <= 1'b0;
      txn_done <= 1'b0;
      if (!reset_n || clr)
      begin
         busy <= 1'b0;
         n_txn <= 3'h0;
      end
      else if (txn_start)
      begin
         busy <= 1'b1;
         n_txn <= n_txn + 3'h1;
         left <= cfg_babble ? txn_len + 12'h001 : (n_txn == {1'b0, cfg_short_at} - 3'h1 ? 12'h00a : txn_len);
         txn_bytes <= cfg_babble ? txn_len + 12'h001 : (n_txn == {1'b0, cfg_short_at} - 3'h1 ? 12'h00a : txn_len);
         if (n_txn == 3'h0)
         begin
            len0 <= txn_len;
            addr0 <= txn_buf_addr;
         end
      end
      else if (busy && left != 12'h000)
      begin
         data_step <= 1'b1;
         left <= left - 12'h001;
      end
      else if (busy)
      begin
         busy <= 1'b0;
         txn_done <= 1'b1;
      end
      if (txn_done && n_txn == 3'h1)
         addr1 <= txn_buf_addr;
   end
endmodule : uits_far_model
`default_nettype wire

/* verif/uits_sched_test.sv */
`default_nettype none
// ====================
// Scheduler bench
module uits_sched_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [13:0] fi; logic in; logic [10:0] mps; logic [1:0] mult; logic [11:0] len; logic [2:0] pg;
      logic [11:0] off; logic bab; logic [1:0] short_at; logic skip; logic [1:0] ntx; logic [15:0] st;
      logic [31:0] a0; logic [31:0] a1;
   } uits_row_s;
   logic ref_clk = 1'b0;
   logic reset_n, hsel, hwrite, hready, hreadyout, hresp, mem_req, mem_we, mem_ack, txn_start, txn_in;
   logic data_step, txn_done, txn_error, clr, cfg_babble;
   logic [1:0] htrans, cfg_short_at;
   logic [2:0] hsize, n_txn;
   logic [3:0] txn_ep;
   logic [6:0] txn_dev;
   logic [7:0] wr_count;
   logic [11:0] txn_len, txn_bytes, len0;
   logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata, txn_buf_addr, addr0, addr1, wr_addr, wr_data;
   int n_fail = 0;
   int cmp_count = 0;
   // Descriptors stay within one group and never cross from the last page
   uits_row_s rows [5] = '{
      '{14'h0008, 1'b0, 11'h010, 2'h2, 12'h028, 3'h1, 12'hffc, 1'b0, 2'h0, 1'b0, 2'h2, 16'h0008, 32'h0004_3ffc, 32'h0004_600c},
      '{14'h0010, 1'b1, 11'h020, 2'h3, 12'h040, 3'h0, 12'h000, 1'b1, 2'h0, 1'b1, 2'h0, 16'h2040, 32'h0004_0000, 32'h0004_0021},
      '{14'h0018, 1'b1, 11'h020, 2'h3, 12'h060, 3'h2, 12'h010, 1'b0, 2'h2, 1'b0, 2'h2, 16'h002a, 32'h0004_6010, 32'h0004_6030},
      '{14'h0020, 1'b0, 11'h010, 2'h1, 12'h008, 3'h6, 12'h000, 1'b0, 2'h0, 1'b0, 2'h1, 16'h0000, 32'h0005_2000, 32'h0005_2008},
      '{14'h0026, 1'b0, 11'h010, 2'h1, 12'h008, 3'h3, 12'h100, 1'b0, 2'h0, 1'b0, 2'h1, 16'h0000, 32'h0004_9100, 32'h0004_9108}};
   assign hready = hreadyout;

   uits_sched uut (.ref_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
      .hrdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .txn_start, .txn_dev, .txn_ep, .txn_in,
      .txn_len, .txn_buf_addr, .data_step, .txn_done, .txn_bytes, .txn_error);
   uits_far_model far (.ref_clk, .reset_n, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .txn_start,
      .txn_len, .txn_buf_addr, .data_step, .txn_done, .txn_bytes, .txn_error, .clr, .cfg_babble, .cfg_short_at, .n_txn,
      .len0, .addr0, .addr1, .wr_count, .wr_addr, .wr_data);

   always #25 ref_clk = ~ref_clk;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge ref_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic fill(input logic [31:0] a, input uits_row_s r, input logic act, input logic [31:0] link);
      for (int w = 1; w < 9; w++) far.mem[a[11:2] + w] = {act, 3'h0, r.len, 1'b0, r.pg, r.off};
      for (int w = 0; w < 7; w++) far.mem[a[11:2] + 9 + w] = 32'h0004_0000 + 32'h3000 * w;
      far.mem[a[11:2]] = link;
      far.mem[a[11:2] + 9] |= 32'h0000_0305;
      far.mem[a[11:2] + 10] |= {20'h0, r.in, r.mps};
      far.mem[a[11:2] + 11] |= {30'h0, r.mult};
   endtask : fill

   task automatic results;
      if (n_fail == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   initial
   begin
      #4000000;
      n_fail++;
      results();
   end

   initial
   begin
      logic [31:0] d, a, fi;
      uits_row_s r;
      logic [7:0] k;
      {reset_n, hsel, hwrite, clr, cfg_babble, htrans, cfg_short_at, haddr, hwdata} = '0;
      hsize = 3'h2;
      for (int w = 0; w < 1024; w++) far.mem[w] = 32'h1;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      chk("mem_req", {31'h0, mem_req}, 32'h0);
      ahb(1'b0, 32'h10, 32'h0, d); chk("caps", d, 32'h2);
      ahb(1'b1, 32'h10, 32'hff, d);
      ahb(1'b0, 32'h10, 32'h0, d); chk("caps_ro", d, 32'h2);
      ahb(1'b1, 32'h40, 32'h5a, d);
      ahb(1'b0, 32'h40, 32'h0, d); chk("unmapped", d, 32'h0);
      ahb(1'b0, 32'h00, 32'h0, d); chk("ctrl", d, 32'h0);
      ahb(1'b1, 32'h0c, 32'h0, d);
      for (int i = 0; i < 5; i++)
      begin
         r = rows[i];
         a = 32'h100 * (i + 1);
         far.mem[r.fi[12:3]] = a;
         if (r.skip) fill(a, r, 1'b0, a + 32'h80);
         fill(a + (r.skip ? 32'h80 : 32'h0), r, 1'b1, 32'h1);
         clr <= 1'b1;
         cfg_babble <= r.bab;
         cfg_short_at <= r.short_at;
         ahb(1'b1, 32'h08, {18'h0, r.fi}, d);
         clr <= 1'b0;
         k = wr_count;
         ahb(1'b1, 32'h00, 32'h1, d);
         for (int t = 0; t < 8000 && wr_count === k; t++) @(posedge ref_clk);
         chk("rec_written", {24'h0, wr_count}, {24'h0, k + 8'h1});
         ahb(1'b0, 32'h08, 32'h0, fi);
         ahb(1'b1, 32'h00, 32'h0, d);
         if (r.skip) a = a + 32'h80;
         chk("rec_addr", wr_addr, a + 32'h4 * (32'h1 + fi[2:0]));
         chk("rec_stat", {16'h0, wr_data[31:16]}, {16'h0, r.st});
         chk("start_addr", addr0, r.a0);
         chk("end_addr", addr1, r.a1);
         chk("first_len", {20'h0, len0}, {20'h0, ({1'b0, r.mps} < r.len ? {1'b0, r.mps} : r.len)});
         if (r.ntx != 2'h0) chk("n_txn", {29'h0, n_txn}, {30'h0, r.ntx});
         ahb(1'b0, 32'h14, 32'h0, d); chk("result", d, wr_data);
         chk("endpoint", {20'h0, txn_in, txn_ep, txn_dev}, {20'h0, r.in, 4'h3, 7'h05});
         ahb(1'b0, 32'h04, 32'h0, d); chk("status", d, 32'h2);
      end
      ahb(1'b1, 32'h00, 32'h1, d);
      ahb(1'b0, 32'h08, 32'h0, a);
      repeat (uits_pkg::UFRAME_CYC - 1) @(posedge ref_clk);
      ahb(1'b0, 32'h08, 32'h0, d); chk("uframe_step", d, a + 32'h1);
      // Reset in mid-run, held long enough that no sampled value spans it
      reset_n <= 1'b0;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      ahb(1'b0, 32'h08, 32'h0, d); chk("fi_reset", d, 32'h0);
      ahb(1'b0, 32'h00, 32'h0, d); chk("run_reset", d, 32'h0);
      results();
   end
endmodule : uits_sched_test
`default_nettype wire
